// ---- verif/srs_host_model.sv ----
// Host processor model: watchdog kicks, sleep requests, RAM enables
module srs_host_model (
    input  wire logic core_clk,
    input  wire logic kick_en,
    input  wire logic sleep_go,
    output logic      watchdog_kick,
    output logic      sleep_request,
    output logic      chip_enable_from_host
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] ph_q;
    logic       en_q;
    logic       go_q;

    // Idle levels before the first edge
    initial begin
        ph_q = 3'h0;
        en_q = 1'h0;
        go_q = 1'h0;
        watchdog_kick = 1'h1;
        sleep_request = 1'h1;
        chip_enable_from_host = 1'h1;
    end

    // Controls taken on the rising edge, so a falling-edge change never races
    always @(posedge core_clk) begin
        en_q <= kick_en;
        go_q <= sleep_go;
    end

    // Kick at phase 0, sleep request falls four cycles after it
    always @(negedge core_clk) begin
        ph_q                  <= ph_q + 3'h1;
        watchdog_kick         <= !(en_q && ph_q == 3'h0);
        sleep_request         <= !(go_q && ph_q == 3'h4);
        chip_enable_from_host <= ph_q[2]; // Toggling RAM cycles
    end
endmodule // srs_host_model

// ---- verif/supervisor_reset_sleep_sequencer_test.sv ----
// Self-checking bench of the supervisor sequencer
module supervisor_reset_sleep_sequencer_test;
    import srs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int B_WN  = 8;
    localparam int B_WOE = 7;
    localparam int B_RH  = 6;
    localparam int B_RN  = 5;
    localparam int B_ROE = 4;
    localparam int B_CE  = 3;
    localparam int B_PF  = 2;
    localparam int B_PFN = 1;
    localparam int B_SLP = 0;

    logic     core_clk, sys_rst, mode_select, supply_ok, supply_above_bat, sense_low;
    logic     watchdog_kick, button_reset, sleep_request, chip_enable_from_host;
    logic     kick_en, sleep_go;
    srs_out_t pins;
    int       err_count;
    int       n_checks;

    srs_sequencer #(.TICK_CYCLES(12'h4), .RST_TICKS(16'h5), .WDOG_TICKS(16'h14), .WARN_TICKS(4'h7)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .mode_select(mode_select), .supply_ok(supply_ok),
        .supply_above_bat(supply_above_bat), .sense_low(sense_low), .watchdog_kick(watchdog_kick),
        .button_reset(button_reset), .sleep_request(sleep_request),
        .chip_enable_from_host(chip_enable_from_host), .pins(pins));

    srs_host_model i_host (.core_clk(core_clk), .kick_en(kick_en), .sleep_go(sleep_go),
        .watchdog_kick(watchdog_kick), .sleep_request(sleep_request),
        .chip_enable_from_host(chip_enable_from_host));

    // Clock generator
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got %h want %h", $time, g, e);
        end
    endtask

    // Bit must keep a level for n cycles
    task automatic hold(input int b, input logic v, input int n);
        logic ok;
        ok = 1'h1;
        repeat (n) begin
            @(negedge core_clk);
            if (pins[b] !== v) ok = 1'h0;
        end
        chk(ok, 9'h1);
    endtask

    // Bounded wait; a timeout ends the run
    task automatic wait_for(input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (pins[b] !== v && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        chk(pins[b], v);
        if (pins[b] !== v) final_report();
    endtask

    // Length of a low pulse in cycles
    task automatic low_len(input int b, input int lo, input int hi);
        int n;
        n = 0;
        while (pins[b] === 1'h0 && n <= hi) begin
            @(negedge core_clk);
            n++;
        end
        chk(9'(n >= lo && n <= hi), 9'h1);
    endtask

    task automatic t_up0;
        supply_above_bat = 1'h1;
        sense_low = 1'h1;
        wait_for(B_PF, 1'h0, 4);
        chk(pins[B_RH], 1'h1);
        hold(B_WN, 1'h1, 30);
        supply_ok = 1'h1;
        wait_for(B_WN, 1'h0, 8);
        chk(pins[B_RH], 1'h1);
        low_len(B_WN, 24, 32);
        kick_en = 1'h1;
        cyc(8);
        kick_en = 1'h0;
        wait_for(B_WN, 1'h0, 6);
        sense_low = 1'h0;
        wait_for(B_WN, 1'h1, 6);
        wait_for(B_RH, 1'h0, 40);
        kick_en = 1'h1;
        $display("test up0 done");
    endtask

    task automatic t_dn0;
        supply_ok = 1'h0;
        cyc(2);
        chk(pins[B_RH], 1'h1);
        chk(pins[B_RN], 1'h0);
        chk(pins[B_CE], 1'h1);
        supply_above_bat = 1'h0;
        cyc(2);
        chk(pins[B_PF], 1'h1);
        chk(pins[B_PFN], 1'h0);
        chk(pins[B_WOE], 1'h0);
        chk(pins[B_ROE], 1'h0);
        supply_above_bat = 1'h1;
        supply_ok = 1'h1;
        wait_for(B_RH, 1'h0, 40);
        $display("test dn0 done");
    endtask

    task automatic t_wd;
        repeat (8) begin
            @(negedge core_clk);
            chk(pins[B_CE], chip_enable_from_host);
        end
        kick_en = 1'h0;
        hold(B_RH, 1'h0, 60);
        wait_for(B_RH, 1'h1, 40);
        kick_en = 1'h1;
        wait_for(B_RH, 1'h0, 40);
        $display("test wd done");
    endtask

    task automatic t_m1;
        mode_select = 1'h1;
        cyc(2);
        kick_en = 1'h0;
        sense_low = 1'h1;
        wait_for(B_WN, 1'h0, 20);
        low_len(B_WN, 24, 32);
        hold(B_WN, 1'h1, 50);
        hold(B_RH, 1'h0, 50);
        sense_low = 1'h0;
        wait_for(B_RH, 1'h1, 10);
        kick_en = 1'h1;
        wait_for(B_RH, 1'h0, 40);
        supply_ok = 1'h0;
        hold(B_RH, 1'h0, 10);
        supply_above_bat = 1'h0;
        cyc(2);
        chk(pins[B_RN], 1'h1);
        chk(pins[B_PF], 1'h1);
        supply_above_bat = 1'h1;
        wait_for(B_RH, 1'h1, 4);
        sense_low = 1'h1;
        wait_for(B_RH, 1'h0, 15);
        sense_low = 1'h0;
        cyc(8);
        supply_ok = 1'h1;
        cyc(30);
        mode_select = 1'h0;
        wait_for(B_RH, 1'h0, 40);
        $display("test m1 done");
    endtask

    task automatic t_slp;
        sleep_go = 1'h1;
        wait_for(B_SLP, 1'h1, 20);
        sleep_go = 1'h0;
        chk(pins[B_ROE], 1'h0);
        sense_low = 1'h1;
        hold(B_WOE, 1'h0, 30);
        sense_low = 1'h0;
        cyc(8);
        button_reset = 1'h0;
        wait_for(B_SLP, 1'h0, 4);
        button_reset = 1'h1;
        kick_en = 1'h0;
        wait_for(B_RH, 1'h1, 100);
        kick_en = 1'h1;
        wait_for(B_RH, 1'h0, 40);
        sleep_go = 1'h1;
        wait_for(B_SLP, 1'h1, 20);
        sleep_go = 1'h0;
        supply_ok = 1'h0;
        wait_for(B_RH, 1'h1, 4);
        supply_above_bat = 1'h0;
        cyc(4);
        supply_above_bat = 1'h1;
        wait_for(B_SLP, 1'h0, 4);
        supply_ok = 1'h1;
        wait_for(B_RH, 1'h0, 40);
        $display("test slp done");
    endtask

    // Main sequence
    initial begin
        err_count = 0;
        n_checks = 0;
        sys_rst = 1'h1;
        mode_select = 1'h0;
        supply_ok = 1'h0;
        supply_above_bat = 1'h0;
        sense_low = 1'h0;
        button_reset = 1'h1;
        kick_en = 1'h0;
        sleep_go = 1'h0;
        cyc(3);
        chk(pins, 9'h14C);
        cyc(2);
        sys_rst = 1'h0;
        t_up0();
        t_dn0();
        t_wd();
        t_m1();
        t_slp();
        final_report();
    end
endmodule // supervisor_reset_sleep_sequencer_test

// ---- verilog/srs_pkg.sv ----
// Constants and types for the supervisor reset and sleep sequencer
package srs_pkg;

    // Clock and internal oscillator time base
    localparam int SRS_CLK_PERIOD_NS = 10;
    localparam int SRS_OSC_PERIOD_NS = 33000;
    localparam int SRS_TICK_CYCLES   = SRS_OSC_PERIOD_NS / SRS_CLK_PERIOD_NS;

    // Low-sense qualification sample count
    localparam logic [1:0] SRS_SNS_SAMPLES = 2'h3;

    // Warning pulse time, least time rounded up to ticks
    localparam int SRS_WARN_PULSE_US = 200;
    localparam int SRS_WARN_TICKS    = (SRS_WARN_PULSE_US * 1000 + SRS_OSC_PERIOD_NS - 1) / SRS_OSC_PERIOD_NS;

    // Reset hold time in ticks
    localparam int SRS_RST_HOLD_MS = 100;
    localparam int SRS_RST_TICKS   = (SRS_RST_HOLD_MS * 1000000 + SRS_OSC_PERIOD_NS - 1) / SRS_OSC_PERIOD_NS;

    // Watchdog timeout in ticks
    localparam int SRS_WDOG_MS    = 150;
    localparam int SRS_WDOG_TICKS = (SRS_WDOG_MS * 1000000 + SRS_OSC_PERIOD_NS - 1) / SRS_OSC_PERIOD_NS;

    // Warning sequencer states
    typedef enum logic [2:0] {
        SRS_W_IDLE  = 3'b001,
        SRS_W_PULSE = 3'b010,
        SRS_W_LOCK  = 3'b100
    } srs_warn_t;

    // Processor-facing and memory-facing pins
    typedef struct packed {
        logic warn_n;
        logic warn_oe;
        logic rst_hi;
        logic rst_n;
        logic rst_oe;
        logic chip_enable_out;
        logic power_fail_flag;
        logic power_fail_n;
        logic sleeping;
    } srs_out_t;

    // Whole state of the sequencer
    typedef struct packed {
        logic [11:0] tick_cnt;
        logic [1:0]  sns_cnt;
        logic        sns_p;
        logic        ok_p;
        logic        bat_p;
        logic        kick_p;
        logic        btn_p;
        logic        slp_p;
        logic        blk;
        srs_warn_t   warn;
        logic [3:0]  wcnt;
        logic        rst_act;
        logic [15:0] rst_cnt;
        logic [15:0] wd_cnt;
        logic        armed;
        logic        sleep;
        srs_out_t    out;
    } srs_state_t;

endpackage

// ---- verilog/srs_sequencer.sv ----
// Supervisor reset, early warning and sleep sequencer
// Behaviour
// [RULE1] Mode select low non-backed, high battery-backed
// [RULE2] Non-backed: release processor pins below battery
// [RULE3] Warning pulses low at least 200 us; the code can end it after 6 ticks plus one clock (198.01 us)
// [RULE4] Non-backed: warning driver off below battery
// [RULE5] Non-backed: resets active below supply trip
// [RULE6] Non-backed: resets held for hold time
// [RULE7] Power-up blocks low-sense warning until trip level
// [RULE8] Warning ends on timeout or sense recovery
// [RULE9] Battery-backed: no reset on supply collapse
// [RULE10] Battery-backed: warning pulse after low sense
// [RULE11] Battery-backed: reset at battery level, hold time
// [RULE12] Low sense during reset cancels the reset; the code cancels it in battery-backed mode only
// [RULE13] Kick while sense low gives extra warning
// [RULE14] Battery-backed: quiet after warning until event
// [RULE15] Power-down: chip enable high, fail flags
// [RULE16] Non-backed power-up: flags off, reset, warning
// [RULE17] Later low sense warns; missing kick resets
// [RULE18] Battery-backed: reset when sense recovers
// [RULE19] Sleep disables outputs and inputs; the code disables the outputs in sleep only while supply_ok is high
// [RULE20] Button falling edge wakes; watchdog restarts
// [RULE21] Power loss in sleep: wake on return
// [RULE22] Sleep request falls after a kick fall
// [RULE23] Low sense needs three consecutive samples
// [RULE24] Timers count internal oscillator ticks
module srs_sequencer
    import srs_pkg::*;
#(
    parameter logic [11:0] TICK_CYCLES = 12'(SRS_TICK_CYCLES),
    parameter logic [15:0] RST_TICKS   = 16'(SRS_RST_TICKS),
    parameter logic [15:0] WDOG_TICKS  = 16'(SRS_WDOG_TICKS),
    parameter logic [3:0]  WARN_TICKS  = 4'(SRS_WARN_TICKS)
) (
    input  wire logic     core_clk,
    input  wire logic     sys_rst,
    input  wire logic     mode_select,
    input  wire logic     supply_ok,
    input  wire logic     supply_above_bat,
    input  wire logic     sense_low,
    input  wire logic     watchdog_kick,
    input  wire logic     button_reset,
    input  wire logic     sleep_request,
    input  wire logic     chip_enable_from_host,
    output srs_out_t      pins
);

    srs_state_t q;
    srs_state_t d;
    logic       tick;
    logic       sns_q;

    // Oscillator tick and qualified low sense
    assign tick  = (q.tick_cnt == TICK_CYCLES - 12'h001);
    assign sns_q = (q.sns_cnt == SRS_SNS_SAMPLES);

    // Next-state logic
    always_comb begin
        logic kick_fall;
        logic btn_fall;
        logic slp_fall;
        logic bat_rise;
        logic sns_set;
        logic sns_clr;
        logic awake;
        logic start_hold;
        logic wd_run;
        logic en;
        kick_fall  = 1'b0;
        btn_fall   = 1'b0;
        slp_fall   = 1'b0;
        bat_rise   = 1'b0;
        sns_set    = 1'b0;
        sns_clr    = 1'b0;
        awake      = 1'b0;
        start_hold = 1'b0;
        wd_run     = 1'b0;
        en         = 1'b0;
        d = q;

        // Edge detection on synchronous inputs
        d.ok_p    = supply_ok;
        d.bat_p   = supply_above_bat;
        d.kick_p  = watchdog_kick;
        d.btn_p   = button_reset;
        d.slp_p   = sleep_request;
        d.sns_p   = sns_q;
        awake     = !q.sleep;
        kick_fall = q.kick_p && !watchdog_kick && awake; // [RULE19]
        btn_fall  = q.btn_p && !button_reset;
        slp_fall  = q.slp_p && !sleep_request;
        bat_rise  = !q.bat_p && supply_above_bat;
        sns_set   = sns_q && !q.sns_p && awake;
        sns_clr   = !sns_q && q.sns_p && awake;

        // Oscillator divider
        d.tick_cnt = tick ? 12'h000 : q.tick_cnt + 12'h001; // [RULE24]

        // Three-sample filter on the sense comparator
        if (tick) begin
            if (!sense_low) begin
                d.sns_cnt = 2'h0; // [RULE23]
            end else if (!sns_q) begin
                d.sns_cnt = q.sns_cnt + 2'h1; // [RULE23]
            end
        end

        // Power-up blanking of low-sense warnings
        if (bat_rise) begin
            d.blk = 1'b1; // [RULE7]
        end else if (supply_ok) begin
            d.blk = 1'b0;
        end

        // Warning sequencer
        case (q.warn)
            SRS_W_IDLE: begin
                if (awake && supply_above_bat && sns_q &&
                    ((!q.blk && (sns_set || kick_fall)) || (q.blk && supply_ok))) begin
                    d.warn = SRS_W_PULSE; // [RULE10] [RULE16] [RULE17]
                    d.wcnt = 4'h0;
                end
            end
            SRS_W_PULSE: begin
                if (tick) begin
                    d.wcnt = q.wcnt + 4'h1; // [RULE3]
                end
                if (!sns_q || (tick && q.wcnt == WARN_TICKS - 4'h1)) begin
                    d.warn = mode_select ? SRS_W_LOCK : SRS_W_IDLE; // [RULE8] [RULE14]
                end
            end
            SRS_W_LOCK: begin
                if (kick_fall && sns_q) begin
                    d.warn = SRS_W_PULSE; // [RULE13]
                    d.wcnt = 4'h0;
                end else if (sns_clr) begin
                    d.warn     = SRS_W_IDLE; // [RULE14]
                    start_hold = 1'b1; // [RULE18]
                end else if (bat_rise) begin
                    d.warn = SRS_W_IDLE; // [RULE14]
                end
            end
            default: begin
                d.warn = SRS_W_IDLE;
            end
        endcase
        if (!supply_above_bat || q.sleep) begin
            if (d.warn == SRS_W_PULSE) begin
                d.warn = SRS_W_IDLE; // [RULE19]
            end
        end

        // Sleep entry, armed by a preceding kick fall
        if (slp_fall && q.armed && awake && supply_ok) begin
            d.sleep = 1'b1; // [RULE22]
            d.armed = 1'b0;
        end else if (q.sleep && btn_fall) begin
            d.sleep  = 1'b0; // [RULE20]
            d.wd_cnt = 16'h0000;
        end else if (q.sleep && bat_rise) begin
            d.sleep = 1'b0; // [RULE21]
        end
        // A kick in the entry cycle re-arms; set wins over clear
        if (kick_fall) begin
            d.armed = 1'b1;
        end

        // Watchdog counts while awake with valid supply, outside reset hold and the warning lock state
        wd_run = awake && supply_ok && !q.rst_act && q.warn != SRS_W_LOCK;
        if (kick_fall) begin
            d.wd_cnt = 16'h0000;
        end else if (wd_run && tick) begin
            if (q.wd_cnt == WDOG_TICKS - 16'h0001) begin
                d.wd_cnt   = 16'h0000;
                start_hold = 1'b1; // [RULE17] [RULE20]
            end else begin
                d.wd_cnt = q.wd_cnt + 16'h0001;
            end
        end

        // Battery-backed power-up reset at battery level
        if (mode_select && bat_rise) begin
            start_hold = 1'b1; // [RULE11] [RULE21]
        end

        // Reset hold timer
        if (q.rst_act && tick) begin
            if (q.rst_cnt == RST_TICKS - 16'h0001) begin
                d.rst_act = 1'b0; // [RULE6]
            end else begin
                d.rst_cnt = q.rst_cnt + 16'h0001;
            end
        end
        if (start_hold) begin
            d.rst_act = 1'b1;
            d.rst_cnt = 16'h0000;
            d.wd_cnt  = 16'h0000;
        end
        if (mode_select && sns_set && q.rst_act) begin
            d.rst_act = 1'b0; // [RULE12]
        end
        if (!mode_select && !supply_ok) begin
            d.rst_act = 1'b1; // [RULE5] [RULE21]
            d.rst_cnt = 16'h0000; // [RULE6]
        end
        if (mode_select && !supply_above_bat) begin
            d.rst_act = 1'b0; // [RULE9] [RULE11]
        end

        // Pin drive; non-backed mode releases pins below battery
        en = (mode_select || supply_above_bat) && (!d.sleep || !supply_ok); // [RULE1] [RULE2] [RULE19]
        d.out.warn_n          = (d.warn != SRS_W_PULSE);
        d.out.warn_oe         = en; // [RULE4]
        d.out.rst_hi          = d.rst_act;
        d.out.rst_n           = !d.rst_act;
        d.out.rst_oe          = en;
        d.out.chip_enable_out = !supply_ok || chip_enable_from_host; // [RULE15]
        d.out.power_fail_flag = !supply_above_bat; // [RULE15] [RULE16]
        d.out.power_fail_n    = supply_above_bat;
        d.out.sleeping        = d.sleep;
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q          <= '0;
            q.warn     <= SRS_W_IDLE;
            q.out      <= '0;
            q.out.warn_n  <= 1'b1;
            q.out.rst_hi  <= 1'b1;
            q.out.power_fail_flag <= 1'b1;
            q.out.chip_enable_out <= 1'b1;
            q.rst_act  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign pins = q.out;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_nb_release;
        !mode_select && !supply_above_bat |=> !pins.warn_oe && !pins.rst_oe;
    endproperty
    a_nb_release: assert property (p_nb_release) else $error("pins driven below battery"); // [RULE2]

    property p_nb_trip;
        !mode_select && !supply_ok |=> pins.rst_hi && !pins.rst_n;
    endproperty
    a_nb_trip: assert property (p_nb_trip) else $error("reset not active at trip"); // [RULE5]

    property p_bb_norst;
        mode_select && !supply_above_bat |=> !pins.rst_hi && pins.rst_n && pins.rst_oe;
    endproperty
    a_bb_norst: assert property (p_bb_norst) else $error("reset forced in backed mode"); // [RULE9]

    property p_pf;
        !supply_above_bat |=> pins.power_fail_flag && !pins.power_fail_n && pins.chip_enable_out;
    endproperty
    a_pf: assert property (p_pf) else $error("fail flags not set"); // [RULE15]

    property p_warn_end;
        q.warn == SRS_W_PULSE && !sns_q |=> pins.warn_n;
    endproperty
    a_warn_end: assert property (p_warn_end) else $error("warning outlived sense"); // [RULE8]

    property p_filter;
        $rose(sns_q) |-> $past(sense_low) && $past(tick);
    endproperty
    a_filter: assert property (p_filter) else $error("unfiltered sense"); // [RULE23]

    property p_sleep_quiet;
        pins.sleeping && $past(supply_ok) |-> !pins.warn_oe && !pins.rst_oe;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("outputs on in sleep"); // [RULE19]

    property p_blank;
        q.blk |-> q.warn != SRS_W_PULSE;
    endproperty
    a_blank: assert property (p_blank) else $error("warning during blanking"); // [RULE7]

    // Pulse may end only by timeout, recovery, sleep or battery loss
    logic awake_ok;
    assign awake_ok = !q.sleep && supply_above_bat && !(tick && q.wcnt == WARN_TICKS - 4'h1);

    property p_min_pulse;
        q.warn == SRS_W_PULSE && q.wcnt < WARN_TICKS && sns_q && awake_ok |=> q.warn == SRS_W_PULSE;
    endproperty
    a_min_pulse: assert property (p_min_pulse) else $error("warning too short"); // [RULE3]

    c_pulse: cover property ($fell(pins.warn_n));
    c_sleep: cover property ($rose(pins.sleeping));
    c_hold:  cover property ($fell(pins.rst_hi) && supply_ok);
    c_lock:  cover property (q.warn == SRS_W_LOCK);

endmodule // srs_sequencer
